// ### logic/sac_device.sv
/*
  Converter end: conversion sequencing, busy, result transfer and the
  serial readout in internal or external clock mode.
  Assumes the analog core presents its finished code on sample_code and
  that all link inputs are asynchronous to clk.
*/
`timescale 1ns/100ps
module sac_device
  import sac_pkg::*;
#(
  parameter int W = WORD_BITS
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Link to the host
  sac_link_if.device        link,
  // Analog core result
  input  wire logic [W-1:0] sample_code,
  // Status
  output logic              convert_start_n_running
);

  // ===========================================================
  // Synchronisers and edge history
  // ===========================================================
  logic convert_start_n_s1_r;
  logic convert_start_n_s2_r;
  logic convert_start_n_d_r;
  logic cs_s1_r;
  logic cs_s2_r;
  logic src_s1_r;
  logic src_s2_r;
  logic ck_s1_r;
  logic ck_s2_r;
  logic ck_d_r;

  // ===========================================================
  // Conversion and readout state
  // ===========================================================
  logic               busy_r,      busy_nxt;
  logic [CNT_W-1:0]   cnt_r,       cnt_nxt;
  logic [W-1:0]       work_r,      work_nxt;
  logic [W-1:0]       shreg_r,     shreg_nxt;
  logic               bad_r,       bad_nxt;
  logic               irun_r,      irun_nxt;
  logic [4:0]         iph_r,       iph_nxt;
  logic [3:0]         ibit_r,      ibit_nxt;
  logic [3:0]         xcnt_r,      xcnt_nxt;
  logic               data_r,      data_nxt;
  logic               sbclk_r,     sbclk_nxt;
  logic               busy_n_r,    busy_n_nxt;
  logic               data_oe_n_r, data_oe_n_nxt;
  logic               busy_oe_n_r, busy_oe_n_nxt;
  logic               sck_oe_n_r,  sck_oe_n_nxt;

  // Decoded conditions
  logic convert_start_n_fall;
  logic ext_mode;
  logic cs_n;
  logic ck_rise;

  // ===========================================================
  // Next state
  // ===========================================================
  always_comb begin
    convert_start_n_fall     = convert_start_n_d_r && !convert_start_n_s2_r;
    ext_mode      = src_s2_r;
    cs_n          = cs_s2_r;
    ck_rise       = ck_s2_r && !ck_d_r;
    busy_nxt      = busy_r;
    cnt_nxt       = cnt_r;
    work_nxt      = work_r;
    shreg_nxt     = shreg_r;
    bad_nxt       = bad_r;
    irun_nxt      = irun_r;
    iph_nxt       = iph_r;
    ibit_nxt      = ibit_r;
    xcnt_nxt      = xcnt_r;
    data_nxt      = data_r;
    sbclk_nxt     = sbclk_r;

    // Start ignores chip select; edges while busy fall through
    if (!busy_r) begin
      if (convert_start_n_fall) begin
        busy_nxt = 1'b1;
        cnt_nxt  = '0;
        work_nxt = sample_code;
        bad_nxt  = 1'b0;
        irun_nxt = 1'b0;
      end
    end else begin
      cnt_nxt = cnt_r + 1'b1;

      // Host clock high with chip select low near the end spoils it
      if (cnt_r >= CNT_W'(QUIET_FROM_CYC) && ext_mode &&
          ck_s2_r && !cs_n) begin
        bad_nxt = 1'b1;
      end

      // Transfer just before busy; shifter is frozen otherwise
      if (cnt_r == CNT_W'(XFER_CYC)) begin
        if (!(ext_mode && bad_r)) begin
          shreg_nxt = work_r;
          xcnt_nxt  = '0;
        end
      end

      // Internal mode: first bit presented before the first rise
      if (!ext_mode && cnt_r == CNT_W'(FIRST_RISE_CYC - 2)) begin
        irun_nxt = 1'b1;
        iph_nxt  = '0;
        ibit_nxt = '0;
        data_nxt = shreg_r[W-1];
      end

      // End of conversion; clock idles low afterwards, data too in internal mode
      if (cnt_r == CNT_W'(BUSY_CYC - 1)) begin
        busy_nxt  = 1'b0;
        irun_nxt  = 1'b0;
        sbclk_nxt = 1'b0;
        if (!ext_mode) begin
          data_nxt = 1'b0;
        end
      end
    end

    // Internal clock generator: high then low, data moves at the end of low
    if (irun_r) begin
      iph_nxt = (iph_r == 5'(SCLK_PER_CYC - 1)) ? 5'd0 : iph_r + 5'd1;
      if (iph_r == 5'd0) begin
        sbclk_nxt = 1'b1;
      end
      if (iph_r == 5'(SCLK_HI_CYC)) begin
        sbclk_nxt = 1'b0;
        if (ibit_r == 4'(W - 1)) begin
          irun_nxt = 1'b0;
        end else begin
          ibit_nxt = ibit_r + 4'd1;
        end
      end
      // Change data one cycle before the rise, well after the fall
      if (iph_r == 5'(SCLK_PER_CYC - 1)) begin
        data_nxt = shreg_r[W-1-int'(ibit_r)];
      end
    end

    // External mode: each rise moves the next bit out, then zeros
    if (ext_mode && !cs_n && ck_rise) begin
      if (xcnt_r < 4'(W)) begin
        data_nxt = shreg_r[W-1-int'(xcnt_r)];
        xcnt_nxt = xcnt_r + 4'd1;
      end else begin
        data_nxt = 1'b0;
      end
    end
    if (ext_mode) begin
      sbclk_nxt = 1'b0;
      irun_nxt  = 1'b0;
    end

    // Drivers follow chip select; clock only driven in internal mode
    busy_n_nxt    = !busy_nxt;
    data_oe_n_nxt = cs_n;
    busy_oe_n_nxt = cs_n;
    sck_oe_n_nxt  = cs_n || ext_mode;
  end

  // ===========================================================
  // Registers
  // ===========================================================
  always_ff @(posedge clk) begin
    if (srst) begin
      convert_start_n_s1_r   <= 1'b1;
      convert_start_n_s2_r   <= 1'b1;
      convert_start_n_d_r    <= 1'b1;
      cs_s1_r     <= 1'b1;
      cs_s2_r     <= 1'b1;
      src_s1_r    <= 1'b0;
      src_s2_r    <= 1'b0;
      ck_s1_r     <= 1'b0;
      ck_s2_r     <= 1'b0;
      ck_d_r      <= 1'b0;
      busy_r      <= 1'b0;
      cnt_r       <= '0;
      work_r      <= '0;
      shreg_r     <= '0;
      bad_r       <= 1'b0;
      irun_r      <= 1'b0;
      iph_r       <= '0;
      ibit_r      <= '0;
      xcnt_r      <= '0;
      data_r      <= 1'b0;
      sbclk_r     <= 1'b0;
      busy_n_r    <= 1'b1;
      data_oe_n_r <= 1'b1;
      busy_oe_n_r <= 1'b1;
      sck_oe_n_r  <= 1'b1;
    end else begin
      convert_start_n_s1_r   <= link.convert_start_n;
      convert_start_n_s2_r   <= convert_start_n_s1_r;
      convert_start_n_d_r    <= convert_start_n_s2_r;
      cs_s1_r     <= link.chip_select_n;
      cs_s2_r     <= cs_s1_r;
      src_s1_r    <= link.clock_source_select;
      src_s2_r    <= src_s1_r;
      ck_s1_r     <= link.sbclk_line;
      ck_s2_r     <= ck_s1_r;
      ck_d_r      <= ck_s2_r;
      busy_r      <= busy_nxt;
      cnt_r       <= cnt_nxt;
      work_r      <= work_nxt;
      shreg_r     <= shreg_nxt;
      bad_r       <= bad_nxt;
      irun_r      <= irun_nxt;
      iph_r       <= iph_nxt;
      ibit_r      <= ibit_nxt;
      xcnt_r      <= xcnt_nxt;
      data_r      <= data_nxt;
      sbclk_r     <= sbclk_nxt;
      busy_n_r    <= busy_n_nxt;
      data_oe_n_r <= data_oe_n_nxt;
      busy_oe_n_r <= busy_oe_n_nxt;
      sck_oe_n_r  <= sck_oe_n_nxt;
    end
  end

  // ===========================================================
  // Pin drivers, all straight from flops
  // ===========================================================
  assign link.sbclk_dev      = sbclk_r;
  assign link.sbclk_dev_oe_n = sck_oe_n_r;
  assign link.data_o         = data_r;
  assign link.data_oe_n      = data_oe_n_r;
  assign link.busy_n         = busy_n_r;
  assign link.busy_oe_n      = busy_oe_n_r;
  assign convert_start_n_running        = busy_r;

endmodule // sac_device

// ### logic/sac_fifo.sv
/*
  Result FIFO: width and depth are parameters, valid/ready on both sides.
  Assumes a power-of-two depth so the pointers wrap by themselves.
*/
`timescale 1ns/100ps
module sac_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          full_r, full_nxt, val_r, val_nxt, push, pop;

  // Pointer and fill level update
  always_comb begin
    push     = in_valid && !full_r;
    pop      = val_r && out_ready;
    wr_nxt   = push ? wr_r + 1'b1 : wr_r;
    rd_nxt   = pop ? rd_r + 1'b1 : rd_r;
    cnt_nxt  = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    full_nxt = (cnt_nxt == (AW+1)'(DEPTH));
    val_nxt  = (cnt_nxt != '0);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_r   <= '0;
      rd_r   <= '0;
      cnt_r  <= '0;
      full_r <= 1'b0;
      val_r  <= 1'b0;
    end else begin
      wr_r   <= wr_nxt;
      rd_r   <= rd_nxt;
      cnt_r  <= cnt_nxt;
      full_r <= full_nxt;
      val_r  <= val_nxt;
    end
  end

  // Storage needs no reset; validity is tracked by the level
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  assign in_ready  = !full_r;
  assign out_valid = val_r;
  assign out_data  = mem[rd_r];
endmodule // sac_fifo

// ### logic/sac_host.sv
/*
  Host end: paces conversions, reads each result in the selected clock
  mode and queues the words in a FIFO for the user.
  Assumes the converter end sits on the other side of sac_link_if.
*/
`timescale 1ns/100ps
module sac_host
  import sac_pkg::*;
#(
  parameter int W     = WORD_BITS,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Link to the converter
  sac_link_if.host          link,
  // Control
  input  wire logic         run,
  input  wire logic         use_ext,
  // Result stream
  output logic              word_valid,
  input  wire logic         word_ready,
  output logic [W-1:0]      word_data
);

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_START = 3'b001,
    H_WLO   = 3'b010,
    H_WHI   = 3'b011,
    H_READ  = 3'b100,
    H_PUSH  = 3'b101
  } sac_hst_e;

  sac_hst_e         st_r, st_nxt;
  logic [CNT_W-1:0] tmr_r, tmr_nxt;
  logic [4:0]       ph_r, ph_nxt;
  logic [3:0]       nbit_r, nbit_nxt;
  logic [W-1:0]     word_r, word_nxt;
  logic             convert_start_n_n_r, convert_start_n_n_nxt, src_r, src_nxt, sck_r, sck_nxt;
  logic             cs_n_r, bs1_r, bs2_r, ds1_r, ds2_r, ks1_r, ks2_r, kd_r;
  logic             fifo_ready, push;

  // ===========================================================
  // Sequencer
  // ===========================================================
  always_comb begin
    st_nxt     = st_r;
    tmr_nxt    = (tmr_r == CNT_W'(PERIOD_CYC - 1)) ? tmr_r : tmr_r + 1'b1;
    ph_nxt     = ph_r;
    nbit_nxt   = nbit_r;
    word_nxt   = word_r;
    convert_start_n_n_nxt = convert_start_n_n_r;
    src_nxt    = src_r;
    sck_nxt    = sck_r;
    push       = 1'b0;
    case (st_r)
      H_IDLE: begin
        src_nxt = use_ext;
        // Pacing keeps starts 25us apart; a full FIFO stalls here
        if (run && fifo_ready && tmr_r == CNT_W'(PERIOD_CYC - 1)) begin
          tmr_nxt    = '0;
          convert_start_n_n_nxt = 1'b0;
          ph_nxt     = '0;
          nbit_nxt   = '0;
          st_nxt     = H_START;
        end
      end
      H_START: begin
        ph_nxt = ph_r + 5'd1;
        if (ph_r == 5'(CONVERT_START_N_LOW_CYC - 1)) begin
          convert_start_n_n_nxt = 1'b1;
          st_nxt     = H_WLO;
        end
      end
      H_WLO: begin
        if (!bs2_r) begin
          st_nxt = H_WHI;
        end
      end
      H_WHI: begin
        // Internal mode: sample each bit at the falling clock edge
        if (!src_r && kd_r && !ks2_r && nbit_r < 4'(W)) begin
          word_nxt = {word_r[W-2:0], ds2_r};
          nbit_nxt = nbit_r + 4'd1;
        end
        if (bs2_r) begin
          ph_nxt = '0;
          st_nxt = src_r ? H_READ : H_PUSH;
        end
      end
      H_READ: begin
        // Clock only after busy rose, left low afterwards
        ph_nxt = ph_r + 5'd1;
        if (ph_r == 5'(EXT_HALF_CYC - 1)) begin
          ph_nxt  = '0;
          sck_nxt = !sck_r;
          if (sck_r) begin
            word_nxt = {word_r[W-2:0], ds2_r};
            nbit_nxt = nbit_r + 4'd1;
            if (nbit_r == 4'(W - 1)) begin
              st_nxt = H_PUSH;
            end
          end
        end
      end
      H_PUSH: begin
        push   = (nbit_r == 4'(W));
        st_nxt = H_IDLE;
      end
      default: begin
        st_nxt = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r     <= H_IDLE;
      tmr_r    <= '0;
      ph_r     <= '0;
      nbit_r   <= '0;
      word_r   <= '0;
      convert_start_n_n_r <= 1'b1;
      src_r    <= 1'b0;
      sck_r    <= 1'b0;
      cs_n_r   <= 1'b1;
      bs1_r    <= 1'b1;
      bs2_r    <= 1'b1;
      ds1_r    <= 1'b0;
      ds2_r    <= 1'b0;
      ks1_r    <= 1'b0;
      ks2_r    <= 1'b0;
      kd_r     <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      tmr_r    <= tmr_nxt;
      ph_r     <= ph_nxt;
      nbit_r   <= nbit_nxt;
      word_r   <= word_nxt;
      convert_start_n_n_r <= convert_start_n_n_nxt;
      src_r    <= src_nxt;
      sck_r    <= sck_nxt;
      cs_n_r   <= 1'b0;
      bs1_r    <= link.busy_line;
      bs2_r    <= bs1_r;
      ds1_r    <= link.data_line;
      ds2_r    <= ds1_r;
      ks1_r    <= link.sbclk_line;
      ks2_r    <= ks1_r;
      kd_r     <= ks2_r;
    end
  end

  // ===========================================================
  // Result queue and pins
  // ===========================================================
  sac_fifo #(.W(W), .DEPTH(DEPTH)) i_sac_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (word_r),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data)
  );

  assign link.convert_start_n     = convert_start_n_n_r;
  assign link.chip_select_n       = cs_n_r;
  assign link.clock_source_select = src_r;
  assign link.sbclk_host          = sck_r;
  assign link.sbclk_host_oe_n     = !src_r;
endmodule // sac_host

// ### logic/sac_link_if.sv
/*
  Pins between converter and host, with the shared wires resolved.
  Assumes the host keeps chip select and source select stable.
*/
`timescale 1ns/100ps
interface sac_link_if;
  logic convert_start_n;
  logic chip_select_n;
  logic clock_source_select;
  logic sbclk_dev;
  logic sbclk_dev_oe_n;
  logic sbclk_host;
  logic sbclk_host_oe_n;
  logic data_o;
  logic data_oe_n;
  logic busy_n;
  logic busy_oe_n;
  logic sbclk_line;
  logic data_line;
  logic busy_line;

  // Wire levels; undriven clock and data pull low, busy pulls high
  assign sbclk_line = !sbclk_dev_oe_n ? sbclk_dev :
                      (!sbclk_host_oe_n ? sbclk_host : 1'b0);
  assign data_line  = !data_oe_n ? data_o : 1'b0;
  assign busy_line  = !busy_oe_n ? busy_n : 1'b1;

  modport device (
    input  convert_start_n, chip_select_n, clock_source_select, sbclk_line,
    output sbclk_dev, sbclk_dev_oe_n, data_o, data_oe_n, busy_n, busy_oe_n
  );
  modport host (
    output convert_start_n, chip_select_n, clock_source_select,
    output sbclk_host, sbclk_host_oe_n,
    input  sbclk_line, data_line, busy_line
  );
endinterface

// ### logic/sac_pkg.sv
/*
  Shared constants of the sampling converter serial readout: word size,
  link timing at the system clock, and the host's conversion pacing.
  Assumes a single 20 MHz clock on both ends of the link.
*/
// Notes on behaviour
// - Idle falling convert edge holds and starts
// - Convert edges ignored while converting
// - Start does not depend on chip select
// - Host starts at most once per 25us
// - Busy low from start until conversion done
// - Internal mode: previous result sent during conversion
// - Result is 12 bits, MSB first
// - Internal mode: bit stable across both edges
// - Busy low through whole internal transmission
// - Result copied to shifter just before busy
// - External mode: shift only on host clock
// - External mode: host clocks after conversion
// - Internal clock: 1.4us first rise, 1.1us period; here 23 cycles, 1.15us
// - Busy rises 800ns after last clock fall
// - Host clock low 2us before busy rises
// - Convert low at least 40ns, 100ns pulse
// - Convert high 2us before next start
// - Host inputs static late in conversion
// - Codes are two's complement
// - Noisy end window keeps old shifter contents
// - Chip select high floats all outputs
// - Source select picks host or device clock
// - External: rising edge shifts, falling samples
package sac_pkg;

  // ===========================================================
  // Word and clock
  // ===========================================================
  localparam int WORD_BITS = 12;
  localparam int CLK_NS    = 50;
  localparam int CNT_W     = 10;

  // ===========================================================
  // Link times, in ns
  // ===========================================================
  localparam int FIRST_RISE_NS  = 1400;
  localparam int SCLK_HI_NS     = 350;
  localparam int SCLK_LO_NS     = 760;
  localparam int TAIL_NS        = 800;
  localparam int QUIET_NS       = 2000;
  localparam int CONVERT_START_N_PERIOD_NS = 25000;
  localparam int CONVERT_START_N_LOW_NS    = 100;
  localparam int EXT_HALF_NS    = 500;

  // ===========================================================
  // Times in cycles; least times round up
  // ===========================================================
  localparam int FIRST_RISE_CYC = FIRST_RISE_NS / CLK_NS;
  localparam int SCLK_HI_CYC    = SCLK_HI_NS / CLK_NS;
  localparam int SCLK_LO_CYC    = (SCLK_LO_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_PER_CYC   = SCLK_HI_CYC + SCLK_LO_CYC;
  localparam int TAIL_CYC       = TAIL_NS / CLK_NS;
  localparam int QUIET_CYC      = (QUIET_NS + CLK_NS - 1) / CLK_NS;
  localparam int PERIOD_CYC     = (CONVERT_START_N_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONVERT_START_N_LOW_CYC   = (CONVERT_START_N_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int EXT_HALF_CYC   = (EXT_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_CYC       = FIRST_RISE_CYC
                                + (WORD_BITS - 1) * SCLK_PER_CYC
                                + SCLK_HI_CYC + TAIL_CYC;
  localparam int XFER_CYC       = BUSY_CYC - 2;
  localparam int QUIET_FROM_CYC = XFER_CYC - QUIET_CYC;

endpackage

// ### testbench/sac_link_monitor.sv
/*
  Link checker: busy framing, generated clock shape, output enables.
  Assumes the resolved wires of sac_link_if and one clock.
*/
`timescale 1ns/100ps
module sac_link_monitor
  import sac_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic srst,
  // Host pins
  input logic convert_start_n,
  input logic chip_select_n,
  input logic clock_source_select,
  input logic sbclk_line,
  // Device pins
  input logic sbclk_dev,
  input logic sbclk_dev_oe_n,
  input logic data_o,
  input logic data_oe_n,
  input logic busy_n,
  input logic busy_oe_n
);
  // ====================
  // Helpers
  // ====================
  logic [8:0] low_r;
  logic [8:0] low_nxt;
  logic [3:0] quiet_r;
  logic [3:0] quiet_nxt;
  logic       line_r;
  logic       line_nxt;

  // Busy low length; link clock quiet time saturates to stay small
  always_comb begin
    low_nxt   = busy_n ? 9'h000 : low_r + 9'h001;
    quiet_nxt = (quiet_r == 4'hF) ? quiet_r : quiet_r + 4'h1;
    line_nxt  = sbclk_line;
    if (srst || sbclk_line != line_r) quiet_nxt = 4'h0;
    if (srst) low_nxt = 9'h000;
  end

  // Registers only
  always_ff @(posedge clk) begin
    low_r   <= low_nxt;
    quiet_r <= quiet_nxt;
    line_r  <= line_nxt;
  end

  // ====================
  // Assertions
  // ====================
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_start_busy: assert property (
    $fell(convert_start_n) && busy_n |-> ##[1:6] !busy_n
  ) else $error("busy missed a start");
  a_busy_length: assert property (
    $rose(busy_n) |-> low_r >= BUSY_CYC - 1 && low_r <= 9'h190
  ) else $error("busy low length wrong");
  a_frame_busy: assert property (
    $rose(sbclk_dev) |-> !busy_n
  ) else $error("clock outside frame");
  a_clock_high: assert property (
    $rose(sbclk_dev) |-> sbclk_dev [*5] ##[1:6] !sbclk_dev
  ) else $error("clock high time wrong");
  a_bit_hold: assert property (
    $fell(sbclk_dev) |-> (!sbclk_dev && $stable(data_o)) [*8]
  ) else $error("bit or low time short");
  a_bit_stable: assert property (
    sbclk_dev |-> $stable(data_o)
  ) else $error("bit moved while high");
  a_first_rise: assert property (
    $fell(busy_n) && !clock_source_select |-> ##[16:30] $rose(sbclk_dev)
  ) else $error("first clock late");
  a_clock_tail: assert property (
    $rose(busy_n) && !clock_source_select |->
      $past(sbclk_dev, 18) && !$past(sbclk_dev, 14)
  ) else $error("busy tail wrong");
  a_idle_low: assert property (
    busy_n && $past(busy_n, 2) && !clock_source_select |->
      !sbclk_dev && !data_o
  ) else $error("idle outputs not low");
  a_float_cs: assert property (
    chip_select_n && $past(chip_select_n, 2) |->
      busy_oe_n && data_oe_n && sbclk_dev_oe_n
  ) else $error("driving while deselected");
  a_cs_drive: assert property (
    !chip_select_n && !$past(chip_select_n, 3) |-> !busy_oe_n && !data_oe_n
  ) else $error("not driving while selected");
  a_ext_no_drive: assert property (
    clock_source_select && $past(clock_source_select, 3) |-> sbclk_dev_oe_n
  ) else $error("device drives host clock");
  a_ext_hold: assert property (
    clock_source_select && !busy_n && !$past(busy_n, 3) && quiet_r > 4'h8
      |-> $past(data_o, 2) == $past(data_o, 3)
  ) else $error("shifter moved in conversion");
endmodule // sac_link_monitor

// ### testbench/sar_adc_conversion_serial_readout_bench.sv
/*
  Bench: both ends joined by sac_link_if; internal and external readout,
  FIFO fill and drain. Assumes the design files under logic/.
*/
`timescale 1ns/100ps
module sar_adc_conversion_serial_readout_bench;
  import sac_pkg::*;
  // ====================
  // Signals
  // ====================
  logic        clk         = 1'b0;
  logic        srst        = 1'b1;
  logic        run         = 1'b0;
  logic        use_ext     = 1'b0;
  logic        word_ready  = 1'b0;
  logic [11:0] sample_code = 12'h5A3;
  logic        word_valid;
  logic [11:0] word_data;
  logic        convert_start_n_running;
  logic        convert_start_n_q      = 1'b0;
  logic        line_q      = 1'b0;
  logic        busy_q      = 1'b1;
  logic [11:0] shift_w     = 12'h000;
  logic [11:0] sent[$];
  logic [11:0] wire_w[$];
  logic [11:0] codes[8]    = '{12'h7FF, 12'h000, 12'hFFF, 12'h800,
                               12'h001, 12'hA5C, 12'h3C7, 12'hFFE};
  int          errors      = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  int          nxt         = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  // ====================
  // Design and checker
  // ====================
  sac_link_if i_sac_link_if ();
  sac_device i_sac_device (.clk, .srst, .link(i_sac_link_if),
    .sample_code, .convert_start_n_running);
  sac_host i_sac_host (.clk, .srst, .link(i_sac_link_if), .run, .use_ext,
    .word_valid, .word_ready, .word_data);
  sac_link_monitor i_sac_link_monitor (.clk, .srst,
    .convert_start_n(i_sac_link_if.convert_start_n),
    .chip_select_n(i_sac_link_if.chip_select_n),
    .clock_source_select(i_sac_link_if.clock_source_select),
    .sbclk_line(i_sac_link_if.sbclk_line),
    .sbclk_dev(i_sac_link_if.sbclk_dev),
    .sbclk_dev_oe_n(i_sac_link_if.sbclk_dev_oe_n),
    .data_o(i_sac_link_if.data_o),
    .data_oe_n(i_sac_link_if.data_oe_n),
    .busy_n(i_sac_link_if.busy_n),
    .busy_oe_n(i_sac_link_if.busy_oe_n));

  // Record code latched at each start; new code only between conversions
  always @(negedge clk) begin
    convert_start_n_q <= convert_start_n_running;
    if (convert_start_n_running && !convert_start_n_q) sent.push_back(sample_code);
    if (!convert_start_n_running && convert_start_n_q) begin
      sample_code <= codes[nxt];
      nxt         <= (nxt + 1) % 8;
    end
  end

  // Wire frames taken at link clock rises, opposite to the host's edge
  always @(negedge clk) begin
    line_q <= i_sac_link_if.sbclk_line;
    busy_q <= i_sac_link_if.busy_line;
    if (i_sac_link_if.sbclk_line && !line_q && !i_sac_link_if.busy_line)
      shift_w <= {shift_w[10:0], i_sac_link_if.data_line};
    if (i_sac_link_if.busy_line && !busy_q && !use_ext)
      wire_w.push_back(shift_w);
  end

  // Hang guard, well above the expected run length
  always @(negedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      final_report();
    end
  end

  // ====================
  // Tasks
  // ====================
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic do_reset(input logic ext);
    @(negedge clk);
    run     = 1'b0;
    srst    = 1'b1;
    use_ext = ext;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    sent.delete();
    wire_w.delete();
  endtask

  // Waits for a word; index below zero means the all-zero first frame
  task automatic pop(input int i);
    int n;
    n = 0;
    // Let an edge pass so ready never drops and rises in one step
    @(negedge clk);
    while (word_valid !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check(word_data, (i < 0) ? 12'h000 : sent[i]);
    word_ready = 1'b1;
    @(negedge clk);
    word_ready = 1'b0;
  endtask

  // Internal clock: each frame carries the previous result
  task automatic t_internal();
    do_reset(1'b0);
    run = 1'b1;
    for (int k = -1; k < 6; k++) pop(k);
    run = 1'b0;
    for (int k = 0; k < 6; k++) begin
      check(wire_w[k], (k > 0) ? sent[k-1] : 12'h000);
    end
  endtask

  // External clock: result read after its own conversion
  task automatic t_external();
    do_reset(1'b1);
    run = 1'b1;
    for (int k = 0; k < 6; k++) pop(k);
    run = 1'b0;
  endtask

  // Fill until the host stalls, drain to empty, then resume
  task automatic t_fifo();
    int held;
    do_reset(1'b0);
    run = 1'b1;
    repeat (9500) @(negedge clk);
    held = sent.size();
    repeat (1500) @(negedge clk);
    check(12'(sent.size()), 12'(held));
    for (int k = -1; k < 15; k++) pop(k);
    check({11'h000, word_valid}, 12'h000);
    pop(15);
    run = 1'b0;
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    t_internal();
    t_external();
    t_fifo();
    final_report();
  end
endmodule // sar_adc_conversion_serial_readout_bench
